// ==== dltc_pkg.sv ====
// Purpose: shared constants and types of the delay line tap control
// Assumes: apb with 32-bit data, one word per register
// Notes:   all offsets are byte addresses
package dltc_pkg;
  localparam int          TAP_W        = 9;
  localparam int          NUM_TAPS     = 512;
  localparam logic [8:0]  TAP_MAX      = 9'h1FF;
  // register byte offsets
  localparam logic [7:0]  CFG_OFS      = 8'h00;
  localparam logic [7:0]  INIT_OFS     = 8'h04;
  localparam logic [7:0]  TAPPS_OFS    = 8'h08;
  localparam logic [7:0]  STAT_OFS     = 8'h0C;
  // field positions
  localparam int          CFG_TIME_B   = 0;
  localparam int          CFG_INPUT_B  = 1;
  localparam int          STAT_RDY_B   = 9;
  localparam int          STAT_BAD_B   = 10;
  localparam int          STAT_ALN_LSB = 12;
  // reset values
  localparam logic [1:0]  CFG_RST      = 2'h0;
  localparam logic [15:0] INIT_RST     = 16'h0000;
  localparam logic [7:0]  TAPPS_RST    = 8'h05;
  // alignment offset window of an input line in time format
  localparam logic [8:0]  ALIGN_MIN    = 9'h02D;
  localparam logic [8:0]  ALIGN_MAX    = 9'h041;
  localparam logic [8:0]  ALIGN_DEF    = 9'h032;
  // settling figures the fabric side must honour, in cycles
  localparam int          VT_SETTLE    = 10;
  localparam int          TIME_GAP     = 5;
  localparam int          COUNT_GAP    = 4;
  localparam logic [7:0]  CAL_CYC      = 8'h40;

  typedef struct packed {
    logic       load;
    logic       step_en;
    logic       step_up;
    logic       vt_track_enable;
    logic [8:0] tap_load_value;
  } dltc_ctrl_t;

  typedef enum logic [1:0] {
    CAL_IDLE = 2'b00,
    CAL_RUN  = 2'b01,
    CAL_DONE = 2'b11
  } dltc_cal_t;
endpackage : dltc_pkg

// ==== dltc_tap_ctrl.sv ====
// Purpose: tap position control of a 512-tap delay line, variable-load mode
// Assumes: fabric controls come from logic on pclk; apb on pclk
// Notes:   asynchronous update timing only; steps saturate at the ends
//
// Contract
// - taps change by step, by load, by init or by drift
// - position output always shows current tap
// - step moves position one tap up/down
// - load copies load value into position
// - 512 taps, nine-bit count from zero
// - input line adds alignment offset 45..65
// - output line has no alignment offset
// - time format tracks drift in background
// - count format: no calibration, init is taps
// - time format init in ps, runtime taps
// - updates follow the line clock alone
`timescale 1ns/10ps
module dltc_tap_ctrl
  import dltc_pkg::*;
#(
  parameter logic [7:0] CAL_LEN = CAL_CYC
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       psel,
  input  wire logic       penable,
  input  wire logic       pwrite,
  input  wire logic [7:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]     prdata,
  output logic            pready,
  output logic            pslverr,
  input  dltc_ctrl_t      ctrl,
  input  wire logic       vt_drift_up,
  input  wire logic       vt_drift_dn,
  output logic [8:0]      tap_position_out,
  output logic            cal_ready
);

  // ***********************
  //  register file
  // ***********************
  logic [1:0]  cfg_r;
  logic [15:0] init_r;
  logic [7:0]  tapps_r;
  logic        bad_r;
  logic [8:0]  pos_r;
  logic [8:0]  align_r;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  logic        init_go_r;
  logic        mapped;
  logic        wr_acc;
  logic        bad_now;
  logic [31:0] rd_mux;

  assign mapped = (paddr == CFG_OFS) || (paddr == INIT_OFS) ||
                  (paddr == TAPPS_OFS) || (paddr == STAT_OFS);
  assign wr_acc = psel && penable && pready_r && pwrite && mapped;
  assign bad_now = ctrl.load && ctrl.step_en;

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      CFG_OFS:   rd_mux[1:0]  = cfg_r;
      INIT_OFS:  rd_mux[15:0] = init_r;
      TAPPS_OFS: rd_mux[7:0]  = tapps_r;
      STAT_OFS: begin
        rd_mux[8:0]                    = pos_r;
        rd_mux[STAT_RDY_B]             = cal_ready;
        rd_mux[STAT_BAD_B]             = bad_r;
        rd_mux[STAT_ALN_LSB +: TAP_W]  = align_r;
      end
      default:   rd_mux = 32'h0000_0000;
    endcase
  end

  // zero wait states: pready rises in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= psel && !penable;
      pslverr_r <= psel && !penable && !mapped;
      if (psel && !penable) begin
        prdata_r <= rd_mux;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r   <= CFG_RST;
      init_r  <= INIT_RST;
      tapps_r <= TAPPS_RST;
    end else if (wr_acc) begin
      if (paddr == CFG_OFS)   cfg_r   <= pwdata[1:0];
      if (paddr == INIT_OFS)  init_r  <= pwdata[15:0];
      if (paddr == TAPPS_OFS) tapps_r <= pwdata[7:0];
    end
  end

  // invalid combination flag, write one to clear; a new event wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bad_r <= 1'b0;
    end else if (bad_now) begin
      bad_r <= 1'b1;
    end else if (wr_acc && paddr == STAT_OFS && pwdata[STAT_BAD_B]) begin
      bad_r <= 1'b0;
    end
  end

  // ***********************
  //  self-calibration
  // ***********************
  dltc_cal_t  cal_st_r;
  logic [7:0] cal_cnt_r;
  logic       cfg_chg;
  logic       time_fmt;
  logic       is_input;

  assign time_fmt = cfg_r[CFG_TIME_B];
  assign is_input = cfg_r[CFG_INPUT_B];
  assign cfg_chg  = wr_acc && (paddr == CFG_OFS) && (pwdata[1:0] != cfg_r);

  // count format never calibrates; a format change restarts it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_st_r  <= CAL_IDLE;
      cal_cnt_r <= 8'h00;
    end else if (cfg_chg) begin
      cal_st_r  <= CAL_IDLE;
      cal_cnt_r <= 8'h00;
    end else begin
      unique case (cal_st_r)
        CAL_IDLE: if (time_fmt) cal_st_r <= CAL_RUN;
        CAL_RUN: begin
          cal_cnt_r <= cal_cnt_r + 8'h01;
          if (cal_cnt_r == CAL_LEN - 8'h01) cal_st_r <= CAL_DONE;
        end
        CAL_DONE: cal_st_r <= CAL_DONE;
        default:  cal_st_r <= CAL_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_ready <= 1'b0;
      align_r   <= 9'h000;
    end else begin
      cal_ready <= (cal_st_r == CAL_DONE) && !cfg_chg;
      if (cal_st_r == CAL_RUN && cal_cnt_r == CAL_LEN - 8'h01) begin
        align_r <= is_input ? ALIGN_DEF : 9'h000;
      end else if (cfg_chg || !time_fmt) begin
        align_r <= 9'h000;
      end
    end
  end

  // initial setting is applied after reset, on an init or config write, and
  // once calibration completes in time format
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_go_r <= 1'b1;
    end else begin
      init_go_r <= (wr_acc && (paddr == INIT_OFS || paddr == CFG_OFS)) ||
                   (cal_st_r == CAL_RUN && cal_cnt_r == CAL_LEN - 8'h01);
    end
  end

  // ***********************
  //  initial setting in taps
  // ***********************
  logic [15:0] ps_taps;
  logic [16:0] init_sum;
  logic [8:0]  init_tap;

  // divider is combinational; init is rare so its depth is tolerated
  assign ps_taps  = (tapps_r == 8'h00) ? init_r : init_r / {8'h00, tapps_r};
  assign init_sum = {1'b0, ps_taps} + {8'h00, align_r};
  assign init_tap = !time_fmt ? (init_r > 16'(TAP_MAX) ? TAP_MAX
                                : init_r[8:0]) :
                    (init_sum > 17'(TAP_MAX) ? TAP_MAX
                                : init_sum[8:0]);

  // ***********************
  //  tap position
  // ***********************
  logic vt_ok;
  assign vt_ok = time_fmt && cal_ready && ctrl.vt_track_enable &&
                 !ctrl.load && !ctrl.step_en;

  // priority: load, step, init, then drift; explicit fabric control
  // always beats the background nudges
  // every change happens on pclk only, no data transition involved
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_r <= 9'h000;
    end else if (ctrl.load && !ctrl.step_en) begin
      pos_r <= ctrl.tap_load_value;
    end else if (ctrl.step_en && !ctrl.load) begin
      if (ctrl.step_up && pos_r != TAP_MAX) begin
        pos_r <= pos_r + 9'h001;
      end else if (!ctrl.step_up && pos_r != 9'h000) begin
        pos_r <= pos_r - 9'h001;
      end
    end else if (init_go_r && !(time_fmt && !cal_ready &&
                 cal_st_r != CAL_DONE && init_r != INIT_RST)) begin
      pos_r <= init_tap;
    end else if (vt_ok && vt_drift_up && !vt_drift_dn && pos_r != TAP_MAX) begin
      pos_r <= pos_r + 9'h001;
    end else if (vt_ok && vt_drift_dn && !vt_drift_up && pos_r != 9'h000) begin
      pos_r <= pos_r - 9'h001;
    end
  end

  assign tap_position_out = pos_r;
  assign prdata           = prdata_r;
  assign pready           = pready_r;
  assign pslverr          = pslverr_r;

  // ***********************
  //  assertions
  // ***********************
  sequence s_load_only;
    ctrl.load && !ctrl.step_en;
  endsequence

  sequence s_step(logic up);
    ctrl.step_en && !ctrl.load && ctrl.step_up == up;
  endsequence

  load_takes_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_load_only |=> tap_position_out == $past(ctrl.tap_load_value))
    else $error("load value not taken");

  step_up_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_step(1'b1) ##0 (pos_r != TAP_MAX) |=> pos_r == $past(pos_r) + 9'h001)
    else $error("step up did not add one");

  step_dn_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_step(1'b0) ##0 (pos_r != 9'h000) |=> pos_r == $past(pos_r) - 9'h001)
    else $error("step down did not take one");

  bad_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    bad_now && !init_go_r && !vt_ok |=> $stable(pos_r) && bad_r)
    else $error("invalid combination moved taps");

  idle_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl.load && !ctrl.step_en && !init_go_r && !vt_ok |=> $stable(pos_r))
    else $error("taps moved with no control");

  nocal_cnt_a: assert property (@(posedge pclk) disable iff (!presetn)
    !time_fmt && !cfg_chg |=> !cal_ready && align_r == 9'h000)
    else $error("count format calibrated");

  align_in_a: assert property (@(posedge pclk) disable iff (!presetn)
    cal_ready && is_input |-> align_r >= ALIGN_MIN && align_r <= ALIGN_MAX)
    else $error("alignment offset out of range");

  out_noalign_a: assert property (@(posedge pclk) disable iff (!presetn)
    !is_input && $rose(cal_ready) |-> align_r == 9'h000)
    else $error("output line has an offset");

  cal_time_a: assert property (@(posedge pclk) disable iff (!presetn)
    time_fmt && cal_st_r == CAL_IDLE && !cfg_chg |-> ##[1:80] cal_ready)
    else $error("calibration never finished");

  vt_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl.vt_track_enable && !ctrl.load && !ctrl.step_en && !init_go_r
    |=> $stable(pos_r))
    else $error("drift moved taps without tracking");

  // apb handshake, zero wait states
  sequence s_apb_setup;
    psel && !penable;
  endsequence

  rdy_first_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_apb_setup |=> pready)
    else $error("pready missing in access cycle");

  rdy_pulse_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("pready stood two cycles");

  slverr_map_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_apb_setup ##0 !mapped |=> pslverr)
    else $error("unmapped access without error");

  // saturation at both ends of the line
  sat_top_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_step(1'b1) ##0 (pos_r == TAP_MAX) |=> pos_r == TAP_MAX)
    else $error("step up wrapped past the top");

  sat_bot_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_step(1'b0) ##0 (pos_r == 9'h000) |=> pos_r == 9'h000)
    else $error("step down wrapped past zero");

  bad_set_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    bad_now |=> bad_r)
    else $error("invalid combination not flagged");

  bad_clear_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !bad_now && wr_acc && paddr == STAT_OFS && pwdata[STAT_BAD_B]
    |=> !bad_r)
    else $error("invalid flag not cleared");

  cal_drop_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    cfg_chg |=> !cal_ready)
    else $error("ready kept across format change");

  init_count_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    init_go_r && !time_fmt && !ctrl.load && !ctrl.step_en
    |=> pos_r == $past(init_tap))
    else $error("count format init not applied");

  vt_up_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    vt_ok && vt_drift_up && !vt_drift_dn && !init_go_r && pos_r != TAP_MAX
    |=> pos_r == $past(pos_r) + 9'h001)
    else $error("drift nudge not applied");
endmodule : dltc_tap_ctrl

// ==== dltc_fabric_model.sv ====
// Purpose: fabric-side model driving the tap controls
// Assumes: one request at a time; op 0 load, 1 up, 2 down, 3 both
// Notes:   one fixed spacing covers the gaps of both formats
`timescale 1ns/10ps
module dltc_fabric_model
  import dltc_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       go,
  input  wire logic [1:0] op,
  input  wire logic [8:0] val,
  input  wire logic       vt_on,
  output dltc_ctrl_t      ctrl,
  output logic            done,
  output logic            busy
);
  logic [2:0] cnt_r;

  assign busy = (cnt_r != 3'h0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 3'h0;
      ctrl  <= '0;
      done  <= 1'b0;
    end else begin
      done                 <= (cnt_r == 3'h2);
      ctrl.load            <= 1'b0; // one-cycle strobe
      ctrl.step_en         <= 1'b0;
      // tracking off while any control moves
      ctrl.vt_track_enable <= vt_on && !busy && !go;
      if (!busy && go) begin
        cnt_r               <= 3'h1;
        ctrl.tap_load_value <= val; // value a cycle ahead
        ctrl.step_up        <= (op == 2'h1);
      end else if (cnt_r == 3'h1) begin
        cnt_r        <= 3'h2;
        // both together only when op 3 asks for it
        ctrl.load    <= (op == 2'h0) || (op == 2'h3);
        ctrl.step_en <= (op != 2'h0);
      end else if (busy) begin
        // spacing of seven covers five and four
        cnt_r <= (cnt_r == 3'h6) ? 3'h0 : cnt_r + 3'h1;
      end
    end
  end
endmodule : dltc_fabric_model

// ==== delay_line_tap_load_control_test.sv ====
// Purpose: self-checking bench of the tap control
// Assumes: zero-wait apb, fabric model on the control side
// Notes:   drift nudges driven by the bench; expectations queued by drivers
`timescale 1ns/10ps
module delay_line_tap_load_control_test;
  import dltc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        cal_ready, go, vt_on, done, busy, drift_up, drift_dn;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0]  op;
  logic [8:0]  val, v, tap_position_out;
  logic [64:0] note;
  dltc_ctrl_t  ctrl;
  logic [64:0] apb_q[$];
  logic [8:0]  pos_q[$];
  int          err_count, total_checks, cyc;

  dltc_tap_ctrl #(.CAL_LEN(8'h08)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ctrl(ctrl), .vt_drift_up(drift_up),
    .vt_drift_dn(drift_dn), .tap_position_out(tap_position_out),
    .cal_ready(cal_ready));
  dltc_fabric_model fab (.pclk(pclk), .presetn(presetn), .go(go),
    .op(op), .val(val), .vt_on(vt_on), .ctrl(ctrl), .done(done),
    .busy(busy));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // ****************
  // checking
  // ****************
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task final_report;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report

  always @(posedge pclk) begin
    if (psel && penable && pready && apb_q.size() > 0) begin
      note = apb_q.pop_front();
      chk({31'h0, pslverr}, {31'h0, note[0]});
      chk(prdata & note[32:1], note[64:33] & note[32:1]);
    end
    if (done && pos_q.size() > 0)
      chk({23'h0, tap_position_out}, {23'h0, pos_q.pop_front()});
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      $display("ERROR %0t: run hung", $time);
      final_report;
    end
  end

  // ****************
  // drivers
  // ****************
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           input logic [31:0] m, input logic e);
    int k;
    apb_q.push_back({d, m, e});
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (!pready && k < 40);
    if (!pready) begin
      err_count++;
      $display("ERROR %0t: no pready", $time);
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task tap(input logic [1:0] o, input logic [8:0] x, input logic [8:0] e);
    int k;
    pos_q.push_back(e);
    @(posedge pclk);
    go  <= 1'b1;
    op  <= o;
    val <= x;
    @(posedge pclk);
    go  <= 1'b0;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (busy && k < 20);
    if (busy) begin
      err_count++;
      $display("ERROR %0t: fabric model stuck", $time);
    end
  endtask : tap

  task wait_cal;
    int k;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (!cal_ready && k < 500);
    if (!cal_ready) begin
      err_count++;
      $display("ERROR %0t: calibration timed out", $time);
    end
  endtask : wait_cal

  // ****************
  // scenarios
  // ****************
  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    go      = 1'b0;
    op      = 2'h0;
    val     = 9'h000;
    vt_on   = 1'b0;
    drift_up = 1'b0;
    drift_dn = 1'b0;
    void'($urandom(32'h8e453aa8));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({23'h0, tap_position_out}, 32'h0);
    apb(1'b0, CFG_OFS, 32'h0, 32'h3, 1'b0);
    apb(1'b0, TAPPS_OFS, {24'h0, TAPPS_RST}, 32'hFF, 1'b0);
    apb(1'b0, 8'h10, 32'h0, 32'hFFFFFFFF, 1'b1);
    apb(1'b1, 8'h14, 32'hFFFF, 32'h0, 1'b1);
    tap(2'h0, TAP_MAX, TAP_MAX);
    tap(2'h0, 9'h000, 9'h000);
    tap(2'h1, 9'h000, 9'h001);
    repeat (4) begin
      v = 9'($urandom_range(511, 0));
      tap(2'h0, v, v);
    end
    tap(2'h0, 9'h1FE, 9'h1FE);
    tap(2'h1, 9'h0AA, 9'h1FF);
    tap(2'h2, 9'h0AA, 9'h1FE);
    tap(2'h3, 9'h0AA, 9'h1FE);
    apb(1'b0, STAT_OFS, 32'h5FE, 32'h7FF, 1'b0);
    apb(1'b1, STAT_OFS, 32'h400, 32'h0, 1'b0);
    repeat (20) @(posedge pclk);
    apb(1'b0, STAT_OFS, 32'h1FE, 32'h7FF, 1'b0);
    apb(1'b1, CFG_OFS, 32'h3, 32'h0, 1'b0);
    wait_cal;
    apb(1'b0, STAT_OFS, {11'h0, ALIGN_DEF, 3'h1, ALIGN_DEF},
        32'h001FF3FF, 1'b0);
    apb(1'b1, INIT_OFS, 32'h0000_02BC, 32'h0, 1'b0);
    v = 9'(16'h02BC / TAPPS_RST) + ALIGN_DEF;
    apb(1'b0, STAT_OFS, {23'h0, v}, 32'h1FF, 1'b0);
    vt_on <= 1'b1;
    repeat (20) @(posedge pclk);
    drift_up <= 1'b1;
    repeat (3) @(posedge pclk);
    drift_up <= 1'b0;
    apb(1'b0, STAT_OFS, {23'h0, v + 9'h003}, 32'h1FF, 1'b0);
    vt_on <= 1'b0;
    repeat (VT_SETTLE) @(posedge pclk);
    v = 9'(16'h0190 / TAPPS_RST) + ALIGN_DEF;
    tap(2'h0, v, v);
    tap(2'h0, 9'h101, 9'h101);
    repeat (VT_SETTLE) @(posedge pclk);
    vt_on <= 1'b1;
    repeat (5) @(posedge pclk);
    apb(1'b1, CFG_OFS, 32'h1, 32'h0, 1'b0);
    wait_cal;
    v = 9'(16'h02BC / TAPPS_RST);
    apb(1'b0, STAT_OFS, {23'h1, v}, 32'h001FF3FF, 1'b0);
    final_report;
  end
endmodule : delay_line_tap_load_control_test
